// ===== rtl/swt_pkg.sv
// Purpose: Shared constants and types of the stopwatch timer
// Assumes: 8-bit register port at the printed byte offsets
// Notes:   Each figure appears here once; logic uses the names
package swt_pkg;

	// Clocks
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned OP_HZ  = 256;
	// Core clock edges per operating tick, for reference only
	localparam int unsigned OP_TICK_CYCLES = CLK_HZ / OP_HZ;

	// Register port widths
	localparam int unsigned ADDR_W = 16;
	localparam int unsigned DATA_W = 8;

	// Register offsets
	localparam logic [15:0] OFF_CONTROL    = 16'h5020;
	localparam logic [15:0] OFF_READOUT    = 16'h5021;
	localparam logic [15:0] OFF_ENABLE     = 16'h5022;
	localparam logic [15:0] OFF_FLAGS      = 16'h5023;
	localparam logic [15:0] OFF_FLAG_CLEAR = 16'h5024;

	// Field positions
	localparam int unsigned CTL_RUN_BIT    = 0;
	localparam int unsigned CTL_CLEAR_BIT  = 4;
	localparam int unsigned CAUSE_HUNDRED  = 0;
	localparam int unsigned CAUSE_TEN      = 1;
	localparam int unsigned CAUSE_ONE      = 2;
	localparam int unsigned NUM_CAUSES     = 3;
	localparam int unsigned READOUT_TENTHS = 4;

	// Reset and idle values
	localparam logic [7:0] BYTE_ZERO  = 8'h00;
	localparam logic [2:0] CAUSE_ZERO = 3'h0;

	// BCD digit
	localparam int unsigned DIGIT_W    = 4;
	localparam logic [3:0]  DIGIT_ZERO = 4'h0;
	localparam logic [3:0]  DIGIT_MAX  = 4'h9;

	// Feedback divider: steps of 2 or 3 operating ticks
	localparam int unsigned DIV_W     = 2;
	localparam logic [1:0]  DIV_ZERO  = 2'h0;
	localparam logic [1:0]  DIV_SHORT = 2'h2;
	localparam logic [1:0]  DIV_LONG  = 2'h3;
	// Tenths holding 26 ticks: six of ten, the rest hold 25
	localparam logic [9:0]  LONG_TENTHS = 10'h2B5;

	typedef enum logic [0:0] {
		ST_STOPPED = 1'b0,
		ST_RUNNING = 1'b1
	} swt_run_state_t;

endpackage

// ===== rtl/swt_fbdiv.sv
// Purpose: Feedback divider giving the approximate 100 Hz step
// Assumes: step_i is one core cycle per counted operating tick
// Notes:   long_i picks a 3-tick step, otherwise 2 ticks
`timescale 1ns/1ps
module swt_fbdiv
	import swt_pkg::*;
(
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Control
	input  wire logic clr_i,
	input  wire logic step_i,
	input  wire logic long_i,
	// Step out
	output logic      done_o
);

	logic [DIV_W-1:0] cnt_reg;
	logic [DIV_W-1:0] cnt_next;
	logic [DIV_W-1:0] len;
	logic [DIV_W-1:0] cnt_inc;

	assign len      = long_i ? DIV_LONG : DIV_SHORT;
	assign cnt_inc  = cnt_reg + 2'h1;
	assign done_o   = step_i && !clr_i && (cnt_inc == len);
	assign cnt_next = (clr_i || done_o) ? DIV_ZERO :
		(step_i ? cnt_inc : cnt_reg);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_reg <= DIV_ZERO;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

endmodule // swt_fbdiv

// ===== rtl/swt_bcd_digit.sv
// Purpose: One BCD digit counting 0 to 9 with carry
// Assumes: clr_i has priority over inc_i
// Notes:   carry_o is combinational, high with the 9 to 0 step
`timescale 1ns/1ps
module swt_bcd_digit
	import swt_pkg::*;
(
	// Clock and reset
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	// Control
	input  wire logic               clr_i,
	input  wire logic               inc_i,
	// Digit out
	output logic [DIGIT_W-1:0]      value_o,
	output logic                    carry_o
);

	logic [DIGIT_W-1:0] digit_reg;
	logic [DIGIT_W-1:0] digit_next;

	assign carry_o    = inc_i && !clr_i && (digit_reg == DIGIT_MAX);
	assign digit_next = (clr_i || carry_o) ? DIGIT_ZERO :
		(inc_i ? digit_reg + 4'h1 : digit_reg);
	assign value_o    = digit_reg;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			digit_reg <= DIGIT_ZERO;
		end else begin
			digit_reg <= digit_next;
		end
	end

endmodule // swt_bcd_digit

// ===== rtl/swt_top.sv
// Purpose: Hundredths-of-a-second stopwatch timer with interrupts
// Assumes: op_clk_i is the 256 Hz level, synchronous to clk_i
// Notes:   Counting happens on falling edges of op_clk_i
//          Flag clear alias sits one byte above the flags
`timescale 1ns/1ps
module swt_top
	import swt_pkg::*;
(
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// Operating clock level
	input  wire logic              op_clk_i,
	// Register port
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [DATA_W-1:0] wdata_i,
	input  wire logic              wr_i,
	input  wire logic              rd_i,
	output logic      [DATA_W-1:0] rdata_o,
	// Interrupt request
	output logic                   irq_o,
	// Counter status
	output logic                   running_o
);

	////////////////////////////////////////////////////////////////////
	// Declarations

	// Stored state and the nets that feed it
	logic                  op_prev_reg;
	logic                  op_fall;
	swt_run_state_t        state_reg;
	swt_run_state_t        state_next;
	logic                  run_reg;
	logic                  run_next;
	logic [NUM_CAUSES-1:0] enable_reg;
	logic [NUM_CAUSES-1:0] enable_next;
	logic [NUM_CAUSES-1:0] flag_reg;
	logic [NUM_CAUSES-1:0] flag_next;
	logic [NUM_CAUSES-1:0] flag_set;
	logic [NUM_CAUSES-1:0] flag_clr;
	logic [DATA_W-1:0]     rdata_reg;
	logic [DATA_W-1:0]     rdata_next;

	// Combinational nets
	logic                  hit_control;
	logic                  hit_readout;
	logic                  hit_enable;
	logic                  hit_flags;
	logic                  hit_flag_clear;
	logic                  wr_control;
	logic                  wr_enable;
	logic                  clr_write;
	logic                  clear_cmd;
	logic                  count_tick;
	logic                  long_step;
	logic                  hund_step;
	logic                  hund_carry;
	logic                  tenth_carry;
	logic                  run_seen;
	logic [DIGIT_W-1:0]    hund_digit;
	logic [DIGIT_W-1:0]    tenth_digit;
	logic [DATA_W-1:0]     control_view;
	logic [DATA_W-1:0]     readout_view;
	logic [DATA_W-1:0]     enable_view;
	logic [DATA_W-1:0]     flags_view;
	logic [DATA_W-1:0]     read_mux;

	////////////////////////////////////////////////////////////////////
	// Helpers

	// Pad a cause vector into a byte; upper bits read zero
	function automatic logic [DATA_W-1:0] cause_byte(
		input logic [NUM_CAUSES-1:0] v
	);
		cause_byte = {{(DATA_W-NUM_CAUSES){1'b0}}, v};
	endfunction

	// Address match for the register port
	function automatic logic addr_hit(
		input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] off
	);
		addr_hit = (a == off);
	endfunction

	////////////////////////////////////////////////////////////////////
	// Address decode

	assign hit_control    = addr_hit(addr_i, OFF_CONTROL);
	assign hit_readout    = addr_hit(addr_i, OFF_READOUT);
	assign hit_enable     = addr_hit(addr_i, OFF_ENABLE);
	assign hit_flags      = addr_hit(addr_i, OFF_FLAGS);
	assign hit_flag_clear = addr_hit(addr_i, OFF_FLAG_CLEAR);

	assign wr_control = wr_i && hit_control;
	assign wr_enable  = wr_i && hit_enable;
	assign clr_write  = wr_i && (hit_flags || hit_flag_clear);

	// Clear is a strobe only; nothing stores it
	assign clear_cmd = wr_control && wdata_i[CTL_CLEAR_BIT];

	////////////////////////////////////////////////////////////////////
	// Operating clock edge and run state

	// Input is synchronous already, so one stage finds the edge
	// Trade-off: one core cycle of latency on every operating edge
	assign op_fall = op_prev_reg && !op_clk_i;

	assign run_next = wr_control ? wdata_i[CTL_RUN_BIT] : run_reg;

	// Run and stop only switch on an operating falling edge
	always_comb begin
		state_next = state_reg;
		if (op_fall) begin
			case (state_reg)
				ST_STOPPED: begin
					if (run_reg) begin
						state_next = ST_RUNNING;
					end
				end
				ST_RUNNING: begin
					if (!run_reg) begin
						state_next = ST_STOPPED;
					end
				end
				default: begin
					state_next = ST_STOPPED;
				end
			endcase
		end
	end

	// Old state gates the tick, so a stop still counts the "+1"
	assign count_tick = op_fall && (state_reg == ST_RUNNING);

	// Run bit reads 1 until counting has really halted
	assign run_seen  = run_reg || (state_reg == ST_RUNNING);
	assign running_o = (state_reg == ST_RUNNING);

	////////////////////////////////////////////////////////////////////
	// Counting chain

	// Odd hundredths take 3 ticks; digit 0 does too in long tenths.
	// That gives 25 or 26 ticks a tenth, 4 short to 6 long.
	assign long_step = hund_digit[0] ||
		((hund_digit == DIGIT_ZERO) && LONG_TENTHS[tenth_digit]);

	// Clear outranks the tick in the same cycle, then counting goes on
	// Limitation: a tick falling with the clear write is dropped
	swt_fbdiv u_div (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.clr_i  (clear_cmd),
		.step_i (count_tick),
		.long_i (long_step),
		.done_o (hund_step)
	);

	swt_bcd_digit u_hund (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.clr_i   (clear_cmd),
		.inc_i   (hund_step),
		.value_o (hund_digit),
		.carry_o (hund_carry)
	);

	swt_bcd_digit u_tenth (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.clr_i   (clear_cmd),
		.inc_i   (hund_carry),
		.value_o (tenth_digit),
		.carry_o (tenth_carry)
	);

	////////////////////////////////////////////////////////////////////
	// Interrupt flags

	// Each step marks the falling edge of its rate signal
	always_comb begin
		flag_set = CAUSE_ZERO;
		flag_set[CAUSE_HUNDRED] = hund_step;
		flag_set[CAUSE_TEN]     = hund_carry;
		flag_set[CAUSE_ONE]     = tenth_carry;
	end

	assign flag_clr = clr_write ? wdata_i[NUM_CAUSES-1:0] : CAUSE_ZERO;

	// Set is applied last so a coinciding event is never lost
	assign flag_next = (flag_reg & ~flag_clr) | flag_set;

	// Enables only gate the line; they never touch the flags
	assign enable_next = wr_enable ? wdata_i[NUM_CAUSES-1:0] : enable_reg;

	// Flags set regardless; only enabled ones reach the line
	assign irq_o = |(flag_reg & enable_reg);

	////////////////////////////////////////////////////////////////////
	// Read path

	always_comb begin
		control_view = BYTE_ZERO;
		control_view[CTL_RUN_BIT] = run_seen;
	end

	// Readout is not latched; software pairs two reads to catch a ripple
	assign readout_view = {tenth_digit, hund_digit};
	assign enable_view  = cause_byte(enable_reg);
	assign flags_view   = cause_byte(flag_reg);

	// Clear register is write-only; unmapped addresses read zero
	assign read_mux =
		hit_control ? control_view :
		hit_readout ? readout_view :
		hit_enable  ? enable_view  :
		hit_flags   ? flags_view   : BYTE_ZERO;

	// Data stands only in the cycle after the read strobe
	assign rdata_next = rd_i ? read_mux : BYTE_ZERO;
	assign rdata_o    = rdata_reg;

	////////////////////////////////////////////////////////////////////
	// Registers

	// Low after reset, matching the idle level, so no false edge
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			op_prev_reg <= 1'b0;
		end else begin
			op_prev_reg <= op_clk_i;
		end
	end

	// Run state
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= ST_STOPPED;
		end else begin
			state_reg <= state_next;
		end
	end

	// Software run bit
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			run_reg <= 1'b0;
		end else begin
			run_reg <= run_next;
		end
	end

	// Enable mask
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			enable_reg <= CAUSE_ZERO;
		end else begin
			enable_reg <= enable_next;
		end
	end

	// Sticky flags
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			flag_reg <= CAUSE_ZERO;
		end else begin
			flag_reg <= flag_next;
		end
	end

	// Read data, zero outside the answer cycle
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_reg <= BYTE_ZERO;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

endmodule // swt_top

// ===== bench/swt_top_asserts.sv
// Purpose: Port-level assertions of the stopwatch timer
// Assumes: Sees only the top ports; bound below
// Notes:   Op clock falls judged from its sampled level
`timescale 1ns/1ps
module swt_top_asserts
	import swt_pkg::*;
(
	// Clock and reset
	input wire logic              clk_i,
	input wire logic              rst_i,
	// Watched ports
	input wire logic              op_clk_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] wdata_i,
	input wire logic              wr_i,
	input wire logic              rd_i,
	input wire logic [DATA_W-1:0] rdata_o,
	input wire logic              irq_o,
	input wire logic              running_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_rdata_idle_zero: assert property (!rd_i |=> rdata_o == 8'h00)
		else $error("read data not zero outside a read");
	a_digits_bcd: assert property (rd_i && addr_i == OFF_READOUT
		|=> rdata_o[7:4] <= 4'h9 && rdata_o[3:0] <= 4'h9)
		else $error("readout digit above nine");
	a_ctl_res_zero: assert property (rd_i && addr_i == OFF_CONTROL
		|=> rdata_o[7:1] == 7'h00)
		else $error("control clear or reserved bit reads one");
	a_ena_res_zero: assert property (rd_i && addr_i == OFF_ENABLE
		|=> rdata_o[7:3] == 5'h00)
		else $error("enable reserved bits read one");
	a_flg_res_zero: assert property (rd_i && addr_i == OFF_FLAGS
		|=> rdata_o[7:3] == 5'h00)
		else $error("flag reserved bits read one");
	a_run_on_fall: assert property ($changed(running_o)
		|-> $past(op_clk_i, 2) && !$past(op_clk_i))
		else $error("run state changed off an operating fall");
	a_run_bit_held: assert property (rd_i && addr_i == OFF_CONTROL
		&& running_o |=> rdata_o[0])
		else $error("run bit read zero while counting");
	a_run_write_kept: assert property (wr_i && addr_i == OFF_CONTROL
		&& wdata_i[0] ##1 !wr_i ##1 rd_i && addr_i == OFF_CONTROL
		|=> rdata_o[0])
		else $error("written run bit not read back");
	a_irq_rise_cause: assert property ($rose(irq_o) |-> $past(wr_i)
		|| ($past(op_clk_i, 3) && !$past(op_clk_i, 2))
		|| ($past(op_clk_i, 2) && !$past(op_clk_i)))
		else $error("interrupt rose without tick or write");
	a_irq_fall_write: assert property ($fell(irq_o) |-> $past(wr_i))
		else $error("interrupt dropped without a write");
endmodule // swt_top_asserts

bind swt_top swt_top_asserts swt_top_asserts_i (
	.clk_i(clk_i), .rst_i(rst_i), .op_clk_i(op_clk_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
	.rdata_o(rdata_o), .irq_o(irq_o), .running_o(running_o));

// ===== bench/swt_opclk_src.sv
// Purpose: Operating clock source in place of the clock generator
// Assumes: Sped up: HALF core cycles high, HALF low
// Notes:   Runs free, as the real one does while its oscillator runs
`timescale 1ns/1ps
module swt_opclk_src #(
	parameter int HALF = 4
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Operating clock level
	output logic      op_clk_o
);
	int cnt_reg;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_reg  <= 0;
			op_clk_o <= 1'b0;
		end else if (cnt_reg == HALF - 1) begin
			cnt_reg  <= 0;
			op_clk_o <= ~op_clk_o;
		end else begin
			cnt_reg <= cnt_reg + 1;
		end
	end
endmodule // swt_opclk_src

// ===== bench/swt_tb_top.sv
// Purpose: Self-checking bench of the stopwatch timer
// Assumes: Operating clock 8 core cycles a tick
// Notes:   Expected values follow the register map only
`timescale 1ns/1ps
module swt_tb_top
	import swt_pkg::*;
;
	logic              clk_i;
	logic              rst_i;
	logic              op_clk;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic              wr;
	logic              rd;
	logic [DATA_W-1:0] rdata;
	logic              irq;
	logic              running;
	logic [7:0]        v;
	int                fail_count;
	int                n_checks;

	swt_top swt_top_i (.clk_i(clk_i), .rst_i(rst_i), .op_clk_i(op_clk),
		.addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
		.rdata_o(rdata), .irq_o(irq), .running_o(running));
	swt_opclk_src #(.HALF(4)) swt_opclk_src_i (.clk_i(clk_i),
		.rst_i(rst_i), .op_clk_o(op_clk));

	////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e,
		input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	// Gap edge before each strobe, so no signal is set twice at once
	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk_i);
		wr    <= 1'b0;
		#1;
	endtask
	task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
		@(posedge clk_i);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk_i);
		rd   <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic rd_chk(input string n, input logic [15:0] a,
		input logic [7:0] e);
		logic [7:0] d;
		rd_reg(a, d);
		chk(n, e, d);
	endtask
	task automatic wait_flag(input logic [7:0] m);
		logic [7:0] d;
		d = 8'h00;
		for (int k = 0; k < 3000 && (d & m) == 8'h00; k++)
			rd_reg(OFF_FLAGS, d);
		if ((d & m) == 8'h00) begin
			chk("flag wait", m, d);
			end_sim();
		end
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	initial begin
		rst_i = 1'b1;
		addr = 16'h0000;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		fail_count = 0;
		n_checks = 0;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		rd_chk("ctl", OFF_CONTROL, BYTE_ZERO);
		rd_chk("cnt", OFF_READOUT, BYTE_ZERO);
		rd_chk("ena", OFF_ENABLE, BYTE_ZERO);
		rd_chk("flg", OFF_FLAGS, BYTE_ZERO);
		rd_chk("gap", 16'h5030, BYTE_ZERO);
		wr_reg(OFF_ENABLE, 8'h07);
		rd_chk("ena", OFF_ENABLE, 8'h07);
		wr_reg(OFF_READOUT, 8'h55);
		rd_chk("cnt", OFF_READOUT, BYTE_ZERO);
		wr_reg(OFF_ENABLE, BYTE_ZERO);
		$display("test registers done");
		wr_reg(OFF_FLAGS, 8'h07);
		wr_reg(OFF_CONTROL, 8'h11);
		wait_flag(8'h02);
		rd_chk("cnt", OFF_READOUT, 8'h10);
		chk("irq", 8'h00, {7'h00, irq});
		wr_reg(OFF_CONTROL, 8'h00);
		for (int k = 0; k < 40 && running !== 1'b0; k++)
			@(posedge clk_i);
		chk("run", 8'h00, {7'h00, running});
		if (running !== 1'b0)
			end_sim();
		rd_chk("flg", OFF_FLAGS, 8'h03);
		wr_reg(OFF_FLAGS, 8'h00);
		rd_chk("flg", OFF_FLAGS, 8'h03);
		wr_reg(OFF_ENABLE, 8'h02);
		chk("irq", 8'h01, {7'h00, irq});
		wr_reg(OFF_FLAGS, 8'h02);
		chk("irq", 8'h00, {7'h00, irq});
		rd_chk("flg", OFF_FLAGS, 8'h01);
		wr_reg(OFF_FLAGS, 8'h01);
		rd_chk("flg", OFF_FLAGS, BYTE_ZERO);
		$display("test flags done");
		rd_reg(OFF_READOUT, v);
		rd_chk("twice", OFF_READOUT, v);
		repeat (100) @(posedge clk_i);
		rd_chk("held", OFF_READOUT, v);
		wr_reg(OFF_CONTROL, 8'h10);
		rd_chk("ctl", OFF_CONTROL, BYTE_ZERO);
		repeat (100) @(posedge clk_i);
		rd_chk("cnt", OFF_READOUT, BYTE_ZERO);
		$display("test stop done");
		wr_reg(OFF_CONTROL, 8'h01);
		rd_chk("ctl", OFF_CONTROL, 8'h01);
		wait_flag(8'h04);
		rd_chk("cnt", OFF_READOUT, BYTE_ZERO);
		wr_reg(OFF_FLAG_CLEAR, 8'h04);
		rd_reg(OFF_FLAGS, v);
		chk("alias", 8'h00, v & 8'h04);
		rd_chk("clrreg", OFF_FLAG_CLEAR, BYTE_ZERO);
		wr_reg(OFF_CONTROL, 8'h11);
		rd_chk("cnt", OFF_READOUT, BYTE_ZERO);
		repeat (200) @(posedge clk_i);
		rd_reg(OFF_READOUT, v);
		chk("resume", 8'h01, {7'h00, v !== 8'h00});
		rd_chk("ctl", OFF_CONTROL, 8'h01);
		$display("test clear done");
		end_sim();
	end
endmodule // swt_tb_top
